// [verilog/serial_flash_id_readout.sv]
// identification read-out command interpreter of a serial flash
`timescale 1ns/10ps
`default_nettype none
module serial_flash_id_readout
    import id_readout_pkg::*;
#(
    parameter logic [7:0] MANUF_CODE = MANUF_CODE_DEF,  // arbitrary value
    parameter logic [7:0] MEM_TYPE   = MEM_TYPE_DEF,    // arbitrary value
    parameter logic [7:0] CAPACITY   = CAPACITY_DEF,    // arbitrary value
    parameter logic [7:0] LEGACY_DEV = LEGACY_DEV_DEF,  // arbitrary value
    parameter logic [7:0] SIGNATURE  = SIGNATURE_DEF    // arbitrary value
)(
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic cs_n,
    input  wire logic sck,
    input  wire logic si,
    input  wire logic array_busy,
    output var  logic so,
    output var  logic so_oe,
    output var  logic id_cmd_seen
);

    // ----------------------------------------------------------------
    // pin sampling
    // ----------------------------------------------------------------
    spi_in_s pins;
    spi_in_s level;
    spi_ev_s ev;

    assign pins = '{cs_n: cs_n, sck: sck, si: si};

    spi_pin_sync u_sync (
        .clock (clock),
        .nrst  (nrst),
        .pins  (pins),
        .level (level),
        .ev    (ev)
    );

    // busy comes from the array controller on this clock
    logic busy_q;

    always_ff @(posedge clock) begin
        if (!nrst) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= array_busy;
        end
    end

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    phase_e     phase_q;
    logic [7:0] shift_in_q;
    logic [2:0] bit_cnt_q;
    logic [4:0] addr_cnt_q;
    logic       addr_lsb_q;
    logic [1:0] byte_idx_q;
    logic [7:0] out_q;
    logic [2:0] out_bit_q;
    logic       legacy_sel_q;
    logic       so_q;
    logic       so_oe_q;
    logic       seen_q;

    logic [7:0] opcode_next;
    logic       byte_done;
    assign opcode_next = {shift_in_q[6:0], level.si};
    assign byte_done   = (bit_cnt_q == 3'd7);

    // byte to present for the standard id read, by byte index
    function automatic logic [7:0] std_byte(input logic [1:0] idx);
        unique case (idx)
            2'd0:    std_byte = MANUF_CODE;
            2'd1:    std_byte = MEM_TYPE;
            default: std_byte = CAPACITY;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // command phase sequencing
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!nrst) begin
            phase_q    <= ST_IDLE;
            bit_cnt_q  <= 3'd0;
            shift_in_q <= 8'h00;
            addr_cnt_q <= ADDR_CNT_RST;
            addr_lsb_q <= 1'b0;
        end else if (!ev.active) begin
            phase_q   <= ST_IDLE;
            bit_cnt_q <= 3'd0;
        end else if (ev.start || phase_q == ST_IDLE) begin
            phase_q    <= ST_OPCODE;
            bit_cnt_q  <= 3'd0;
            addr_cnt_q <= ADDR_CNT_RST;
        end else if (ev.rise) begin
            shift_in_q <= opcode_next;
            bit_cnt_q  <= bit_cnt_q + 3'd1;
            unique case (phase_q)
                ST_OPCODE: begin
                    if (byte_done) begin
                        if (opcode_next == OP_STD_ID) begin
                            phase_q <= ST_STD_OUT;
                        end else if (opcode_next == OP_LEGACY_A || opcode_next == OP_LEGACY_B) begin
                            phase_q <= ST_ADDR;
                        end else if (opcode_next == OP_SIGNATURE && !busy_q) begin
                            phase_q <= ST_SIG_OUT;
                        end else begin
                            phase_q <= ST_IGNORE;
                        end
                    end
                end
                ST_ADDR: begin
                    addr_cnt_q <= addr_cnt_q + 5'd1;
                    if (addr_cnt_q == 5'(ADDR_BITS - 1)) begin
                        addr_lsb_q <= level.si;
                        phase_q    <= ST_LEG_OUT;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // output shifter, loads on the first falling edge of each byte
    // ----------------------------------------------------------------
    logic out_mode;
    assign out_mode = (phase_q == ST_STD_OUT) || (phase_q == ST_LEG_OUT) || (phase_q == ST_SIG_OUT);

    logic [7:0] load_byte;
    always_comb begin
        load_byte = 8'h00;
        unique case (phase_q)
            ST_STD_OUT: load_byte = std_byte(byte_idx_q);
            ST_LEG_OUT: load_byte = (legacy_sel_q ^ addr_lsb_q) ? LEGACY_DEV : MANUF_CODE;
            ST_SIG_OUT: load_byte = SIGNATURE;
            default:    load_byte = 8'h00;
        endcase
    end

    // capacity byte repeats after the third; host ends with chip select
    always_ff @(posedge clock) begin
        if (!nrst) begin
            out_q        <= 8'h00;
            out_bit_q    <= 3'd0;
            byte_idx_q   <= BYTE_IDX_RST;
            legacy_sel_q <= 1'b0;
            so_q         <= 1'b0;
            so_oe_q      <= 1'b0;
        end else if (!out_mode) begin
            out_bit_q    <= 3'd0;
            byte_idx_q   <= BYTE_IDX_RST;
            legacy_sel_q <= 1'b0;                        // a0 lands with the phase change, so it is applied at load
            so_oe_q      <= 1'b0;
            so_q         <= 1'b0;
        end else if (ev.fall) begin
            so_oe_q <= 1'b1;
            if (out_bit_q == 3'd0) begin
                so_q  <= load_byte[7];
                out_q <= {load_byte[6:0], 1'b0};
                if (byte_idx_q != 2'd2) begin
                    byte_idx_q <= byte_idx_q + 2'd1;
                end
                legacy_sel_q <= !legacy_sel_q;
            end else begin
                so_q  <= out_q[7];
                out_q <= {out_q[6:0], 1'b0};
            end
            out_bit_q <= out_bit_q + 3'd1;
        end
    end

    // sticky marker: any identification command that reached its output phase since reset
    always_ff @(posedge clock) begin
        if (!nrst) begin
            seen_q <= 1'b0;
        end else if (out_mode) begin
            seen_q <= 1'b1;
        end
    end

    assign so          = so_q;
    assign so_oe       = so_oe_q;
    assign id_cmd_seen = seen_q;

endmodule
`default_nettype wire

// [verilog/id_readout_pkg.sv]
// package: opcodes, identity defaults, carrier structs for the id read-out block
package id_readout_pkg;

    // ----------------------------------------------------------------
    // opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_STD_ID     = 8'h9F;
    localparam logic [7:0] OP_LEGACY_A   = 8'h90;
    localparam logic [7:0] OP_LEGACY_B   = 8'hAB;
    localparam logic [7:0] OP_NOP        = 8'h00;
    // signature read opcode: arbitrary value, identity of this core
    localparam logic [7:0] OP_SIGNATURE  = 8'hA5;

    // ----------------------------------------------------------------
    // identity codes (all values arbitrary and neutral)
    // ----------------------------------------------------------------
    localparam logic [7:0] MANUF_CODE_DEF  = 8'h5A;
    localparam logic [7:0] MEM_TYPE_DEF    = 8'h31;
    localparam logic [7:0] CAPACITY_DEF    = 8'h42;
    localparam logic [7:0] LEGACY_DEV_DEF  = 8'h63;
    localparam logic [7:0] SIGNATURE_DEF   = 8'h77;

    // ----------------------------------------------------------------
    // field sizes and reset values
    // ----------------------------------------------------------------
    localparam int         BYTE_BITS     = 8;
    localparam int         ADDR_BITS     = 24;
    localparam logic [4:0] ADDR_CNT_RST  = 5'h00;
    localparam logic [1:0] BYTE_IDX_RST  = 2'h0;

    // ----------------------------------------------------------------
    // carrier structs and command phase enum
    // ----------------------------------------------------------------
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic si;
    } spi_in_s;

    typedef struct packed {
        logic rise;
        logic fall;
        logic active;
        logic start;
    } spi_ev_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_OPCODE,
        ST_ADDR,
        ST_STD_OUT,
        ST_LEG_OUT,
        ST_SIG_OUT,
        ST_IGNORE
    } phase_e;

endpackage

// [verilog/spi_pin_sync.sv]
// pin synchroniser and edge finder for chip select, serial clock and data in
`timescale 1ns/10ps
`default_nettype none
module spi_pin_sync
    import id_readout_pkg::*;
(
    input  wire logic    clock,
    input  wire logic    nrst,
    input  wire spi_in_s pins,
    output var spi_in_s  level,
    output var spi_ev_s  ev
);

    // ----------------------------------------------------------------
    // two-stage synchroniser
    // ----------------------------------------------------------------
    spi_in_s meta_q;
    spi_in_s sync_q;
    spi_in_s prev_q;

    // stage one feeds only stage two; idle level is deselected
    always_ff @(posedge clock) begin
        if (!nrst) begin
            meta_q <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
            sync_q <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
            prev_q <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
        end else begin
            meta_q <= pins;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // ----------------------------------------------------------------
    // edge events on the synchronised copies
    // ----------------------------------------------------------------
    always_comb begin
        level     = sync_q;
        ev.active = !sync_q.cs_n;
        ev.start  = prev_q.cs_n && !sync_q.cs_n;
        ev.rise   = !sync_q.cs_n && !prev_q.sck && sync_q.sck;
        ev.fall   = !sync_q.cs_n && prev_q.sck && !sync_q.sck;
    end

endmodule
`default_nettype wire

// [tb/serial_flash_id_readout_props.sv]
// checker: timing relations at the ports of the id read-out block
`timescale 1ns/10ps
`default_nettype none
module serial_flash_id_readout_props (
    input wire logic clock,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic array_busy,
    input wire logic so,
    input wire logic so_oe,
    input wire logic id_cmd_seen
);
    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // reset clears all outputs; not disabled by reset itself
    property p_reset; disable iff (1'b0) !nrst |=> !so && !so_oe && !id_cmd_seen; endproperty
    a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
    property p_so_idle; !so_oe |-> !so; endproperty
    a_so_idle: assert property (p_so_idle) else $error("so high while not driven");
    property p_cs_release; cs_n [*5] |-> !so_oe; endproperty
    a_cs_release: assert property (p_cs_release) else $error("output still driven after deselect");
    property p_oe_drop; $fell(so_oe) |-> $past(cs_n, 2); endproperty
    a_oe_drop: assert property (p_oe_drop) else $error("output released while selected");
    property p_oe_hold; so_oe && !cs_n |=> so_oe; endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("output dropped during frame");
    property p_oe_start; $rose(so_oe) |-> !cs_n; endproperty
    a_oe_start: assert property (p_oe_start) else $error("output driven while deselected");
    // so moves only shortly after a serial clock fall
    property p_so_edge; so_oe && $changed(so) |-> !$past(sck, 2); endproperty
    a_so_edge: assert property (p_so_edge) else $error("so changed outside low phase");
    property p_seen; so_oe ##1 so_oe |-> id_cmd_seen ##1 id_cmd_seen; endproperty
    a_seen: assert property (p_seen) else $error("id seen flag not set");
endmodule
bind serial_flash_id_readout serial_flash_id_readout_props u_props (.clock(clock), .nrst(nrst), .cs_n(cs_n),
    .sck(sck), .si(si), .array_busy(array_busy), .so(so), .so_oe(so_oe), .id_cmd_seen(id_cmd_seen));
`default_nettype wire

// [tb/spi_host_model.sv]
// host serial controller model: frames, clocks out bits, samples replies
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
    input  wire logic clock,
    input  wire logic so,
    input  wire logic so_oe,
    output var  logic cs_n,
    output var  logic sck,
    output var  logic si
);
    initial begin
        cs_n = 1'b1;
        sck  = 1'b0;
        si   = 1'b0;
    end
    // one frame, tx msb first; reply sampled late in high phase for slack
    task automatic frame(input logic [31:0] tx, input int ntx, input int nrx,
                         output logic [31:0] rx, output logic oe);
        rx = '0;
        oe = 1'b0;
        @(negedge clock);
        cs_n = 1'b0;
        for (int i = 0; i < ntx + nrx; i++) begin
            sck = 1'b0;
            si  = (i < ntx) ? tx[31-i] : ~si; // released line toggles
            repeat (4) @(negedge clock);
            sck = 1'b1;
            repeat (3) @(negedge clock);
            if (i >= ntx) begin
                rx = {rx[30:0], so};
                oe = oe | so_oe;
            end
            @(negedge clock);
        end
        sck = 1'b0;
        repeat (4) @(negedge clock);
        cs_n = 1'b1;
        repeat (8) @(negedge clock);
    endtask
endmodule
`default_nettype wire

// [tb/serial_flash_id_readout_bench.sv]
// self-checking bench for the id read-out block
`timescale 1ns/10ps
`default_nettype none
module serial_flash_id_readout_bench;
    import id_readout_pkg::*;
    logic        clock, nrst, cs_n, sck, si, array_busy, so, so_oe, id_cmd_seen, oe;
    logic [31:0] rx;
    int          n_errors = 0;
    int          checks_done = 0;
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    serial_flash_id_readout u_dut (.clock(clock), .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si),
        .array_busy(array_busy), .so(so), .so_oe(so_oe), .id_cmd_seen(id_cmd_seen));
    spi_host_model u_host (.clock(clock), .so(so), .so_oe(so_oe), .cs_n(cs_n), .sck(sck), .si(si));
    // ----------------------------------------------------------------
    // helpers and scenarios
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic t_std;
        u_host.frame({OP_STD_ID, 24'h0}, 8, 32, rx, oe);
        check("std id", {MANUF_CODE_DEF, MEM_TYPE_DEF, CAPACITY_DEF, CAPACITY_DEF}, rx);
        check("seen", 32'h1, {31'h0, id_cmd_seen});
    endtask
    // deselect after four bits, then a no-op frame must stay silent
    task automatic t_abort;
        u_host.frame({OP_STD_ID, 24'h0}, 8, 4, rx, oe);
        check("abort nibble", {28'h0, MANUF_CODE_DEF[7:4]}, rx);
        check("abort oe", 32'h0, {31'h0, so_oe});
        u_host.frame({OP_NOP, 24'h0}, 8, 8, rx, oe);
        check("nop oe", 32'h0, {31'h0, oe});
    endtask
    task automatic t_legacy(input logic [7:0] op, input logic a0);
        u_host.frame({op, 23'h0, a0}, 32, 24, rx, oe);
        check("legacy", a0 ? {8'h0, LEGACY_DEV_DEF, MANUF_CODE_DEF, LEGACY_DEV_DEF}
                           : {8'h0, MANUF_CODE_DEF, LEGACY_DEV_DEF, MANUF_CODE_DEF}, rx);
    endtask
    // signature read, then refused while the array is busy
    task automatic t_sig;
        u_host.frame({OP_SIGNATURE, 24'h0}, 8, 16, rx, oe);
        check("signature", {16'h0, SIGNATURE_DEF, SIGNATURE_DEF}, rx);
        @(negedge clock);
        array_busy = 1'b1;
        u_host.frame({OP_SIGNATURE, 24'h0}, 8, 8, rx, oe);
        check("busy oe", 32'h0, {31'h0, oe});
        @(negedge clock);
        array_busy = 1'b0;
        // busy seen clear, so the next signature read must be served
        u_host.frame({OP_SIGNATURE, 24'h0}, 8, 8, rx, oe);
        check("sig after busy", {24'h0, SIGNATURE_DEF}, rx);
    endtask
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        array_busy = 1'b0;
        repeat (8) @(negedge clock);
        nrst = 1'b1;
        repeat (4) @(negedge clock);
        check("reset outs", 32'h0, {29'h0, so, so_oe, id_cmd_seen});
        t_std();
        t_abort();
        t_legacy(OP_LEGACY_A, 1'b0);
        t_legacy(OP_LEGACY_A, 1'b1);
        t_legacy(OP_LEGACY_B, 1'b0);
        t_legacy(OP_LEGACY_B, 1'b1);
        t_sig();
        end_sim();
    end
endmodule
`default_nettype wire
